// >>> pkg/spi_cmd_pkg.sv
// Constants and types shared by the command-driven serial slave port.
package spi_cmd_pkg;
    // Byte, count and buffer index widths.
    localparam int BYTE_W = 8;
    localparam int CNT_W = 6;
    localparam int IDX_W = 3;
    localparam int AVAIL_W = 4;
    localparam int BIT_W = 3;
    // Buffer depth in bytes, for both directions.
    localparam int BUF_DEPTH = 8;
    // Operation field position inside a command byte.
    localparam int OP_HI = 7;
    localparam int OP_LO = 6;
    // Bit counter values in the link domain.
    localparam logic [BIT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BIT_W-1:0] BIT_ONE = 3'h1;
    // Count values used by the command engine.
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] STATUS_BYTES = 6'h02;
    localparam logic [CNT_W-1:0] RX_CAP = 6'h08;
    // Status reply prefixes.
    localparam logic [1:0] PFX_SEND = 2'h1;
    localparam logic [1:0] PFX_RECV = 2'h0;
    // Bytes ready to send after reset: the whole buffer.
    localparam logic [AVAIL_W-1:0] AVAIL_MAX = 4'h8;
    // Synchroniser bit positions and their reset pattern.
    localparam int SYNC_LD = 0;
    localparam int SYNC_RX = 1;
    localparam int SYNC_CS = 2;
    localparam logic [2:0] SYNC_RST = 3'h4;
    // Operation selected by the top two command bits.
    typedef enum logic [1:0] {
        OP_STATUS = 2'h0,
        OP_SEND = 2'h1,
        OP_RECV = 2'h2,
        OP_DUPLEX = 2'h3
    } op_e;
endpackage // spi_cmd_pkg

// >>> pkg/link_if.sv
// Word and event carrier between the serial shifter and the command core.
interface link_if;
    import spi_cmd_pkg::*;
    logic [BYTE_W-1:0] tx_word; // Next byte to shift out, held by the core.
    logic [BYTE_W-1:0] rx_byte; // Last whole byte received.
    logic rx_tgl; // Toggles when a byte has been received.
    logic ld_tgl; // Toggles when a byte starts and the buffer empties.
    modport shifter (input tx_word, output rx_byte, output rx_tgl, output ld_tgl);
    modport core (output tx_word, input rx_byte, input rx_tgl, input ld_tgl);
endinterface // link_if

// >>> hw/sync2.sv
// Two-stage synchroniser for levels entering the system clock domain.
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r; // First stage, read only by the second.
    logic [W-1:0] q_r; // Second stage, safe to use.

    // Both stages load a constant under reset, then shift the input.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end
        else
        begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule // sync2

// >>> hw/serial_shifter.sv
// Link-side byte shifter clocked by the master's serial clock.
module serial_shifter (
    input wire logic i_serial_clock_in,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    link_if.shifter lnk
);
    import spi_cmd_pkg::*;

    logic [BIT_W-1:0] bit_cnt_r; // Bits taken in the current byte.
    logic [BYTE_W-1:0] rx_sh_r; // Incoming shift register.
    logic [BYTE_W-1:0] tx_sh_r; // Outgoing shift register.
    logic sess_rst; // Ends the session at once when deselected.

    // The serial clock stops outside frames, so deselect clears at once.
    assign sess_rst = i_cs_n | ~i_resetn;

    // Rising edge samples the data pin, most significant bit first.
    always_ff @(posedge i_serial_clock_in or posedge sess_rst)
    begin
        if (sess_rst)
        begin
            bit_cnt_r <= BIT_FIRST;
            rx_sh_r <= '0;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_r + BIT_ONE;
            rx_sh_r <= {rx_sh_r[BYTE_W-2:0], i_serial_data_in};
        end
    end

    // The eighth rising edge hands the whole byte to the core.
    always_ff @(posedge i_serial_clock_in or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            lnk.rx_byte <= '0;
            lnk.rx_tgl <= 1'b0;
        end
        else if (!i_cs_n && bit_cnt_r == BIT_LAST)
        begin
            lnk.rx_byte <= {rx_sh_r[BYTE_W-2:0], i_serial_data_in};
            lnk.rx_tgl <= ~lnk.rx_tgl;
        end
    end

    // Falling edge drives the next bit; the first one loads the word.
    always_ff @(negedge i_serial_clock_in or posedge sess_rst)
    begin
        if (sess_rst)
        begin
            o_serial_data_out <= 1'b0;
            tx_sh_r <= '0;
        end
        else if (bit_cnt_r == BIT_FIRST)
        begin
            o_serial_data_out <= lnk.tx_word[BYTE_W-1];
            tx_sh_r <= {lnk.tx_word[BYTE_W-2:0], 1'b0};
        end
        else
        begin
            o_serial_data_out <= tx_sh_r[BYTE_W-1];
            tx_sh_r <= {tx_sh_r[BYTE_W-2:0], 1'b0};
        end
    end

    // A load of the word means the buffer is empty for the next one.
    always_ff @(negedge i_serial_clock_in or negedge i_resetn)
    begin
        if (!i_resetn)
            lnk.ld_tgl <= 1'b0;
        else if (!i_cs_n && bit_cnt_r == BIT_FIRST)
            lnk.ld_tgl <= ~lnk.ld_tgl;
    end
endmodule // serial_shifter

// >>> hw/spi_cmd_slave.sv
// Command-driven serial slave port with chip select and busy handshake.
//
// Summary of operation
// - Shift only on the master's serial clock.
// - Every transfer unit is eight bits.
// - Use clock phase type one on both ends.
// - Most significant bit first both directions.
// - Data output undriven until selected.
// - Full duplex, buffer-empty event per byte.
// - On select: enable output, then busy low.
// - Busy high once command byte starts.
// - Deselect ends session, wait for selection.
// - Each operation starts with one command byte.
// - Low six command bits give byte count.
// - Prefix 01: slave sends counted bytes.
// - Prefix 10: slave receives counted bytes.
// - Prefix 11: counted bytes both ways.
// - Status: 01 send count, 00 receive room.
// - Status command sends exactly two bytes.
// - Send command streams transmit buffer, then ends.
// - Receive command stores complement for sending.
// - Duplex sends, captures, then stores complement.
// - After a command, re-arm and busy low.
// - Output high impedance while not selected.
// - Receive and transmit buffers hold eight bytes.
module spi_cmd_slave (
    input wire logic i_clk, // System clock.
    input wire logic i_resetn, // Reset, low active; synchronous in the core, asynchronous in the shifter.
    input wire logic i_serial_clock_in, // Master's shift clock.
    input wire logic i_cs_n, // Chip select, low active.
    input wire logic i_serial_data_in, // Data from the master.
    output logic o_serial_data_out, // Data to the master.
    output logic o_serial_data_out_oe, // High while the data pin is driven.
    output logic o_busy, // High while the slave is not ready.
    input wire logic i_tx_wr, // Local write into the transmit buffer.
    input wire logic [spi_cmd_pkg::IDX_W-1:0] i_tx_addr,
    input wire logic [spi_cmd_pkg::BYTE_W-1:0] i_tx_data,
    input wire logic [spi_cmd_pkg::IDX_W-1:0] i_rx_addr,
    output logic [spi_cmd_pkg::BYTE_W-1:0] o_rx_data, // Receive buffer read.
    output logic [spi_cmd_pkg::BYTE_W-1:0] o_cmd, // Last command taken.
    output logic o_cmd_done // One-cycle pulse when a command ends.
);
    import spi_cmd_pkg::*;

    // Engine states; codes six and seven are illegal.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT_CMD = 3'h1,
        ST_CMD_RX = 3'h2,
        ST_SETUP = 3'h3,
        ST_XFER = 3'h4,
        ST_FINISH = 3'h5
    } state_e;

    link_if lnk (); // Carrier to the link-side shifter.
    logic [2:0] sync_q; // Synchronised select and event toggles.
    logic [1:0] tgl_prev_r; // Previous toggle levels.
    logic rx_ev; // A byte has been received.
    logic ld_ev; // A byte has started; the buffer is empty.
    logic cs_sel; // The master selects this slave.
    state_e state_r;
    state_e state_nxt;
    op_e op_r; // Operation of the running command.
    logic [CNT_W-1:0] total_r; // Bytes the running command moves.
    logic [CNT_W-1:0] tx_idx_r; // Next byte to hand to the shifter.
    logic [CNT_W-1:0] rx_idx_r; // Bytes finished so far.
    logic [BYTE_W-1:0] tx_buf_r [BUF_DEPTH]; // Transmit buffer.
    logic [BYTE_W-1:0] rx_buf_r [BUF_DEPTH]; // Receive buffer.
    logic [AVAIL_W-1:0] tx_avail_r; // Bytes ready to send.
    logic [BYTE_W-1:0] tx_word_r; // Word offered to the shifter.
    logic busy_r;
    logic oe_r;
    logic [BYTE_W-1:0] cmd_r;
    logic done_r;
    logic [BYTE_W-1:0] rx_data_r;

    // Byte that goes out at position k of the running operation.
    function automatic logic [BYTE_W-1:0] resp_word(input op_e op,
                                                    input logic [CNT_W-1:0] k);
        logic [BYTE_W-1:0] w;
        w = '0;
        unique case (op)
            OP_STATUS:
            begin
                if (k == CNT_ZERO)
                    w = {PFX_SEND, CNT_W'(tx_avail_r)};
                else
                    w = {PFX_RECV, RX_CAP};
            end
            OP_SEND, OP_DUPLEX:
                w = tx_buf_r[k[IDX_W-1:0]];
            OP_RECV:
                w = '0;
        endcase
        return w;
    endfunction

    // The shifter runs on the master's clock and stands at the pins.
    serial_shifter u_shifter (
        .i_serial_clock_in(i_serial_clock_in),
        .i_resetn(i_resetn),
        .i_cs_n(i_cs_n),
        .i_serial_data_in(i_serial_data_in),
        .o_serial_data_out(o_serial_data_out),
        .lnk(lnk.shifter)
    );

    // Select and both event toggles cross into the system clock.
    sync2 #(
        .W(3),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_d({i_cs_n, lnk.rx_tgl, lnk.ld_tgl}),
        .o_q(sync_q)
    );

    // The offered word is set at setup and replaced just after each later load; it reads zero while waiting for a command.
    assign lnk.tx_word = tx_word_r;
    assign cs_sel = ~sync_q[SYNC_CS];
    assign rx_ev = sync_q[SYNC_RX] ^ tgl_prev_r[1];
    assign ld_ev = sync_q[SYNC_LD] ^ tgl_prev_r[0];

    // Remember toggle levels so each change gives one event.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            tgl_prev_r <= '0;
        else
            tgl_prev_r <= sync_q[SYNC_RX:SYNC_LD];
    end

    // Next state; deselect wins over everything.
    always_comb
    begin
        state_nxt = state_r;
        if (!cs_sel)
            state_nxt = ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    state_nxt = ST_WAIT_CMD;
                ST_WAIT_CMD:
                begin
                    if (ld_ev)
                        state_nxt = ST_CMD_RX;
                end
                ST_CMD_RX:
                begin
                    if (rx_ev)
                        state_nxt = ST_SETUP;
                end
                ST_SETUP:
                begin
                    // An empty count ends the command at once.
                    if (total_r == CNT_ZERO)
                        state_nxt = ST_FINISH;
                    else
                        state_nxt = ST_XFER;
                end
                ST_XFER:
                begin
                    if (rx_ev && (rx_idx_r + CNT_ONE) == total_r)
                        state_nxt = ST_FINISH;
                end
                ST_FINISH:
                    state_nxt = ST_WAIT_CMD;
                default:
                    state_nxt = ST_IDLE;
            endcase
        end
    end

    // State register.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Output enable follows selection, one cycle ahead of busy.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            oe_r <= 1'b0;
        else
            oe_r <= (state_nxt != ST_IDLE);
    end

    // Busy is low only while ready for a command, moving data or finishing a command.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            busy_r <= 1'b1;
        else if (!cs_sel)
            busy_r <= 1'b1;
        else
            busy_r <= !(state_r inside {ST_WAIT_CMD, ST_XFER, ST_FINISH});
    end

    // Command decode happens only in the command state.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            cmd_r <= '0;
            op_r <= OP_STATUS;
            total_r <= CNT_ZERO;
        end
        else if (state_r == ST_CMD_RX && rx_ev)
        begin
            cmd_r <= lnk.rx_byte;
            op_r <= op_e'(lnk.rx_byte[OP_HI:OP_LO]);
            if (lnk.rx_byte[OP_HI:OP_LO] == OP_STATUS)
                total_r <= STATUS_BYTES;
            else
                total_r <= lnk.rx_byte[CNT_W-1:0];
        end
    end

    // Feed the shifter: first word at setup, then one per empty event.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            tx_word_r <= '0;
            tx_idx_r <= CNT_ZERO;
        end
        else if (state_r == ST_SETUP)
        begin
            tx_word_r <= resp_word(op_r, CNT_ZERO);
            tx_idx_r <= CNT_ONE;
        end
        else if (state_r == ST_XFER && ld_ev)
        begin
            tx_word_r <= resp_word(op_r, tx_idx_r);
            tx_idx_r <= tx_idx_r + CNT_ONE;
        end
        else if (state_r == ST_WAIT_CMD)
            tx_word_r <= '0;
    end

    // Count finished bytes of the running command.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            rx_idx_r <= CNT_ZERO;
        else if (state_r == ST_SETUP)
            rx_idx_r <= CNT_ZERO;
        else if (state_r == ST_XFER && rx_ev)
            rx_idx_r <= rx_idx_r + CNT_ONE;
    end

    // Capture data bytes; indices past the depth wrap around.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
                rx_buf_r[i] <= '0;
        end
        else if (state_r == ST_XFER && rx_ev && op_r inside {OP_RECV, OP_DUPLEX})
            rx_buf_r[rx_idx_r[IDX_W-1:0]] <= lnk.rx_byte;
    end

    // Store the complement at the end; it wins over a local write.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
                tx_buf_r[i] <= '0;
        end
        else if (state_r == ST_FINISH && op_r inside {OP_RECV, OP_DUPLEX})
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                if (CNT_W'(i) < total_r)
                    tx_buf_r[i] <= ~rx_buf_r[i];
            end
        end
        else if (i_tx_wr)
            tx_buf_r[i_tx_addr] <= i_tx_data;
    end

    // Bytes ready to send: full at reset, then the last stored count.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            tx_avail_r <= AVAIL_MAX;
        else if (state_r == ST_FINISH && op_r inside {OP_RECV, OP_DUPLEX})
        begin
            if (total_r > RX_CAP)
                tx_avail_r <= AVAIL_MAX;
            else
                tx_avail_r <= AVAIL_W'(total_r);
        end
    end

    // Completion pulse and registered receive buffer read.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            done_r <= 1'b0;
            rx_data_r <= '0;
        end
        else
        begin
            done_r <= (state_r == ST_FINISH);
            rx_data_r <= rx_buf_r[i_rx_addr];
        end
    end

    assign o_serial_data_out_oe = oe_r;
    assign o_busy = busy_r;
    assign o_cmd = cmd_r;
    assign o_cmd_done = done_r;
    assign o_rx_data = rx_data_r;

    // Not selected means the data pin is released next cycle.
    property p_release;
        @(posedge i_clk) disable iff (!i_resetn)
        !cs_sel |=> !o_serial_data_out_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data pin driven while deselected");

    // Selection enables the output, then busy falls a cycle later.
    property p_select;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_IDLE && cs_sel) ##1 cs_sel |-> o_serial_data_out_oe ##1 !o_busy;
    endproperty
    a_select: assert property (p_select)
        else $error("select did not enable output then lower busy");

    // The start of a command byte raises busy two cycles on.
    property p_cmd_busy;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_WAIT_CMD && ld_ev) |-> ##2 o_busy;
    endproperty
    a_cmd_busy: assert property (p_cmd_busy)
        else $error("busy not raised when command started");

    // Byte count comes from the low bits, or two for status.
    property p_count;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_CMD_RX && rx_ev) |=> total_r ==
            ((lnk.rx_byte[OP_HI:OP_LO] == OP_STATUS) ? STATUS_BYTES : lnk.rx_byte[CNT_W-1:0]);
    endproperty
    a_count: assert property (p_count)
        else $error("byte count not taken from command");

    // The first status byte reports bytes ready to send.
    property p_status;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_SETUP && op_r == OP_STATUS) |=> tx_word_r == {PFX_SEND, CNT_W'(tx_avail_r)};
    endproperty
    a_status: assert property (p_status)
        else $error("status reply wrong");

    // Finishing re-arms for a command with busy low.
    property p_rearm;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_FINISH && cs_sel) ##1 cs_sel |-> state_r == ST_WAIT_CMD ##1 !o_busy;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("no re-arm after command");

    // A data byte during a command never replaces the command.
    property p_ignore;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_XFER && rx_ev) |=> $stable(cmd_r);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("command replaced while running");

    // Receive and duplex leave the complement of the first byte.
    property p_compl;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_r == ST_FINISH && op_r inside {OP_RECV, OP_DUPLEX} && total_r != CNT_ZERO)
            |=> tx_buf_r[0] == ~rx_buf_r[0];
    endproperty
    a_compl: assert property (p_compl)
        else $error("complement not stored");

    // Deselect returns to idle with busy high.
    property p_deselect;
        @(posedge i_clk) disable iff (!i_resetn)
        !cs_sel |=> state_r == ST_IDLE && o_busy;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselect did not end session");
endmodule // spi_cmd_slave

// >>> bench/spi_master_model.sv
// Serial master model that drives the slave's link pins.
module spi_master_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_busy,
    output logic o_got,
    output logic [7:0] o_got_byte,
    output logic o_timeout
);
    timeunit 1ns;
    timeprecision 100ps;
    // The clock rests high and still outside frames.
    // A short select pulse before the first clock edge gives the link-side flops a clean reset edge.
    initial
    begin
        o_sclk = 1'b1;
        o_cs_n = 1'b0;
        o_mosi = 1'b0;
        o_got = 1'b0;
        o_got_byte = 8'h00;
        o_timeout = 1'b0;
        #1 o_cs_n = 1'b1;
    end
    // Waits for busy low, giving up after a bounded time.
    task automatic wait_ready();
        int n = 0;
        while (i_busy !== 1'b0 && n < 400)
        begin
            #5;
            n++;
        end
        if (n >= 400)
            o_timeout = 1'b1;
    endtask
    // Selects the slave and waits until it is ready.
    task automatic select();
        #1.3;
        o_cs_n = 1'b0;
        wait_ready();
    endtask
    // Releases the select; the data line no longer holds its value.
    task automatic deselect();
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
    endtask
    // Shifts one byte each way and reports what came back.
    task automatic xfer(input logic [7:0] d);
        logic [7:0] r;
        wait_ready();
        #7.7;
        for (int b = 7; b >= 0; b--)
        begin
            o_sclk = 1'b0;
            o_mosi = d[b];
            #40 o_sclk = 1'b1;
            r[b] = i_miso;
            #40;
        end
        o_mosi = ~o_mosi;
        o_got_byte = r;
        o_got = 1'b1;
        #120 o_got = 1'b0;
    endtask
endmodule // spi_master_model

// >>> bench/spi_cmd_slave_tb_top.sv
// Self-checking bench for the command-driven serial slave port.
module spi_cmd_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import spi_cmd_pkg::*;
    logic clk = 1'b0; // System clock.
    logic resetn = 1'b1; // Reset, low active; starts high so its fall is a real edge.
    logic tx_wr = 1'b0; // Local buffer write strobe.
    logic [IDX_W-1:0] tx_addr = '0, rx_addr = '0;
    logic [BYTE_W-1:0] tx_data = '0, rx_data, cmd, got_byte;
    logic sclk, cs_n, mosi, sdo, oe, busy, done, got, timeout;
    tri1 miso; // The shared return line has a pull-up.
    logic [7:0] lfsr = 8'h4a; // Random source, starts at 74.
    logic [7:0] exp_q[$]; // Expected reply bytes, oldest first.
    logic [7:0] txm[8]; // Model of the transmit buffer.
    logic [5:0] ready = 6'h08; // Model of bytes ready to send.
    logic [7:0] cmds[7] = '{8'h00, 8'h48, 8'h83, 8'h00, 8'h45, 8'hc9, 8'h40};
    int bad_count = 0, checks_done = 0, done_cnt = 0, exp_done = 0;
    assign miso = oe ? sdo : 1'bz;
    // Clock generator.
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    spi_cmd_slave spi_cmd_slave_i (.i_clk(clk), .i_resetn(resetn), .i_serial_clock_in(sclk),
        .i_cs_n(cs_n), .i_serial_data_in(mosi), .o_serial_data_out(sdo),
        .o_serial_data_out_oe(oe), .o_busy(busy), .i_tx_wr(tx_wr), .i_tx_addr(tx_addr),
        .i_tx_data(tx_data), .i_rx_addr(rx_addr), .o_rx_data(rx_data), .o_cmd(cmd),
        .o_cmd_done(done));
    spi_master_model spi_master_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso), .i_busy(busy), .o_got(got), .o_got_byte(got_byte),
        .o_timeout(timeout));
    // Next value of the random sequence.
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Compares one byte and counts the outcome.
    task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Notes the expected reply, then shifts the byte.
    task automatic send(input logic [7:0] d, input logic [7:0] e);
        exp_q.push_back(e);
        spi_master_model_i.xfer(d);
    endtask
    // Runs one whole command with random data bytes.
    task automatic run(input logic [7:0] c);
        int n;
        logic [7:0] d;
        logic [7:0] rcv[8];
        n = (c[7:6] == 2'h0) ? 2 : int'(c[5:0]);
        send(c, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            lfsr = next_rand(lfsr);
            d = lfsr;
            rcv[i % 8] = d;
            case (op_e'(c[7:6]))
                OP_STATUS: send(d, i == 0 ? {2'h1, ready} : 8'h08);
                OP_RECV: send(d, 8'h00);
                default: send(d, txm[i % 8]);
            endcase
        end
        // Receiving commands leave the complement ready to send.
        if (c[7])
        begin
            ready = (n > 8) ? 6'h08 : 6'(n);
            for (int i = 0; i < n && i < 8; i++)
            begin
                txm[i] = ~rcv[i];
                @(posedge clk) rx_addr <= 3'(i);
                @(posedge clk);
                @(negedge clk);
                check_byte("receive buffer", rcv[i], rx_data);
            end
        end
        exp_done++;
        check_byte("command", c, cmd);
        $display("command %h finished", c);
    endtask
    // Takes the oldest note whenever a reply byte arrives.
    always @(posedge got)
    begin
        check_byte("reply", exp_q.size() ? exp_q.pop_front() : ~got_byte, got_byte);
    end
    // Counts command completion pulses.
    always @(posedge done)
    begin
        done_cnt++;
    end
    // A master wait that ran out ends the run.
    always @(posedge timeout)
    begin
        bad_count++;
        end_of_test();
    end
    // Overall limit on the run.
    initial
    begin
        #400000;
        bad_count++;
        end_of_test();
    end
    // Main sequence.
    initial
    begin
        // Reset falls at the first edge and is held for two more.
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        check_byte("idle enable", 8'h00, {7'h0, oe});
        for (int i = 0; i < 8; i++)
        begin
            lfsr = next_rand(lfsr);
            txm[i] = lfsr;
            @(posedge clk);
            tx_wr <= 1'b1;
            tx_addr <= 3'(i);
            tx_data <= lfsr;
        end
        @(posedge clk) tx_wr <= 1'b0;
        spi_master_model_i.select();
        check_byte("select enable", 8'h01, {7'h0, oe});
        foreach (cmds[k])
            run(cmds[k]);
        // A receive cut short by deselect stores no complement for sending.
        send(8'h84, 8'h00);
        send(8'h3c, 8'h00);
        spi_master_model_i.deselect();
        repeat (8) @(posedge clk);
        check_byte("deselect enable", 8'h00, {7'h0, oe});
        check_byte("deselect busy", 8'h01, {7'h0, busy});
        $display("abort test finished");
        spi_master_model_i.select();
        run(8'h42);
        repeat (20) @(posedge clk);
        check_byte("done pulses", 8'(exp_done), 8'(done_cnt));
        end_of_test();
    end
endmodule // spi_cmd_slave_tb_top
